// [bench/ahb_host.sv]
// Host side bus master model making single word transfers
`timescale 1ns/1ps
`default_nettype none
module ahb_host (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel = 1'b0,
   output logic [31:0] haddr = 32'h0000_0000,
   output logic [1:0] htrans = 2'b00,
   output logic hwrite = 1'b0,
   output logic [2:0] hsize = 3'h2,
   output logic [31:0] hwdata = 32'h0000_0000
);
   // Address phase held until ready, then data phase held until ready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= w ? d : ~hwdata; // Idle data lines never show the old word
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule
`default_nettype wire

// [bench/power_reset_synth_config_tb_top.sv]
// Self-checking bench for the power, reset and synthesizer configuration block
`timescale 1ns/1ps
`default_nettype none
module power_reset_synth_config_tb_top;
   localparam int RC = 20;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic shutdown_pin = 1'b0;
   logic hsel, hwrite, hreadyout, internal_reset_n, general_io_zero, pad_disable, regulator_bypass, conv_sw_clk;
   logic cal_busy;
   logic [31:0] haddr, hwdata, hrdata, q, obs, w, s;
   logic [1:0] htrans;
   logic [2:0] hsize, conv_level_applied;
   logic [27:0] base_freq_word_out;
   logic [3:0] band_ref_div;
   logic [7:0] cal_word_out;
   logic [31:0] exp_q[$];
   string nm_q[$];
   int failures = 0;
   int compares = 0;
   int seed = 32'he630;
   int n;
   event got;
   // 40 MHz clock
   always #12.5 hclk = ~hclk;
   power_reset_synth_config #(.RESET_CYC(RC)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .shutdown_pin(shutdown_pin), .internal_reset_n(internal_reset_n),
      .general_io_zero(general_io_zero), .pad_disable(pad_disable), .conv_level_applied(conv_level_applied),
      .regulator_bypass(regulator_bypass), .conv_sw_clk(conv_sw_clk), .base_freq_word_out(base_freq_word_out),
      .band_ref_div(band_ref_div), .cal_word_out(cal_word_out), .cal_busy(cal_busy));
   ahb_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, want, seen);
      end
   endtask
   // Monitor takes the oldest expectation whenever a result shows
   always @(got) check(nm_q.pop_front(), obs, exp_q.pop_front());
   task automatic note(input string nm, input logic [31:0] seen, input logic [31:0] want);
      exp_q.push_back(want);
      nm_q.push_back(nm);
      obs = seen;
      -> got;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
      repeat (2) @(negedge hclk);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] want);
      host.xfer(1'b0, a, 32'h0000_0000, q);
      note(nm, q, want);
   endtask
   // Window long enough for a full calibration run
   task automatic wait_cal(input logic want);
      logic seen;
      seen = 1'b0;
      repeat (30) begin
         @(negedge hclk);
         seen = seen | (cal_busy === 1'b1);
      end
      note("cal_busy", 32'(seen), 32'(want));
   endtask
   task automatic pulse_len(input int lo);
      n = 0;
      while (internal_reset_n !== 1'b1 && n < 200) begin
         @(posedge hclk);
         n++;
      end
      note("rst_len", 32'(n >= lo && n <= lo + 3), 32'h1);
   endtask
   // Switch edges over 80 cycles, one either side of nominal allowed for phase
   task automatic toggles(input int lo);
      int t;
      logic p;
      t = 0;
      p = conv_sw_clk;
      repeat (80) begin
         @(negedge hclk);
         t += int'(conv_sw_clk !== p);
         p = conv_sw_clk;
      end
      note("sw_edges", 32'(t >= lo && t <= lo + 2), 32'h1);
   endtask
   task automatic finish_test();
      #1;
      $display("Compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      #100us;
      failures++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (19) @(posedge hclk);
      note("lvl_rst", 32'(conv_level_applied), 32'(prs_pkg::LVL_RESET));
      note("pad_rst", 32'(pad_disable), 32'h1);
      @(posedge hclk);
      hresetn <= 1'b1;
      pulse_len(RC);
      rd("unmapped", 8'h40, 32'h0000_0000);
      rd("conv_rst", prs_pkg::OFS_CONV, 32'h0000_0003);
      wr(prs_pkg::OFS_CONV, 32'h0000_000D);
      w = $random(seed) & 32'h0FFF_FFFF;
      s = $random(seed) & 32'h0000_FFFF;
      wr(prs_pkg::OFS_SYNTH, w);
      wr(prs_pkg::OFS_CHAN, s);
      note("base", 32'(base_freq_word_out), w);
      note("div", 32'(band_ref_div), 32'h0000_0000);
      wr(prs_pkg::OFS_CMD, 32'(prs_pkg::CMD_TX));
      wait_cal(1'b1);
      note("lvl_tx", 32'(conv_level_applied), 32'h0000_0005);
      rd("cal_tx", prs_pkg::OFS_CAL_TX, 32'(s[15:8] ^ w[27:20]));
      wr(prs_pkg::OFS_CMD, 32'(prs_pkg::CMD_RX));
      wait_cal(1'b1);
      note("lvl_rx", 32'(conv_level_applied), 32'h0000_0003);
      rd("cal_rx", prs_pkg::OFS_CAL_RX, 32'(s[15:8] ^ w[27:20]));
      wr(prs_pkg::OFS_CONV, 32'h0000_0005);
      note("lvl_both", 32'(conv_level_applied), 32'h0000_0005);
      wr(prs_pkg::OFS_CONV, 32'h0000_0000);
      note("lvl_keep", 32'(conv_level_applied), 32'h0000_0005);
      // Low-power mode wants bypass with the 1.2 V code
      wr(prs_pkg::OFS_CONV, 32'h0000_0011);
      note("bypass", 32'(regulator_bypass), 32'h1);
      note("lvl_min", 32'(conv_level_applied), 32'(prs_pkg::LVL_MIN));
      // Calibration off: words preloaded by the host are used as they stand
      wr(prs_pkg::OFS_CAL_TX, 32'h0000_005A);
      wr(prs_pkg::OFS_CAL_RX, 32'h0000_00A5);
      wr(prs_pkg::OFS_SYNTH, w | 32'h7000_0000);
      note("div", 32'(band_ref_div), 32'h0000_000C);
      wr(prs_pkg::OFS_CMD, 32'(prs_pkg::CMD_READY));
      wr(prs_pkg::OFS_CMD, 32'(prs_pkg::CMD_TX));
      wait_cal(1'b0);
      note("cal_out", 32'(cal_word_out), 32'h0000_005A);
      wr(prs_pkg::OFS_CMD, 32'(prs_pkg::CMD_SOFT_RESET));
      rd("chan_kept", prs_pkg::OFS_CHAN, s);
      wr(prs_pkg::OFS_CTRL, 32'h0000_0009);
      rd("ctrl", prs_pkg::OFS_CTRL, 32'h0000_0009);
      wr(prs_pkg::OFS_CONV, 32'h0000_0003);
      toggles(39);
      wr(prs_pkg::OFS_CONV, 32'h0000_0043);
      toggles(19);
      wr(prs_pkg::OFS_RATE, 32'h0000_2000);
      wr(prs_pkg::OFS_CONV, 32'h0000_0023);
      toggles(39);
      // Shutdown held well past its minimum width
      @(posedge hclk);
      shutdown_pin <= 1'b1;
      repeat (3) @(negedge hclk);
      note("pad_sd", 32'(pad_disable), 32'h1);
      note("rst_sd", 32'(internal_reset_n), 32'h0);
      @(posedge hclk);
      shutdown_pin <= 1'b0;
      pulse_len(RC);
      note("general_io_zero", 32'(general_io_zero), 32'(internal_reset_n));
      // Second power-on reset in mid-run
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      pulse_len(RC);
      rd("conv_por", prs_pkg::OFS_CONV, 32'h0000_0003);
      rd("chan_por", prs_pkg::OFS_CHAN, 32'h0000_0000);
      finish_test();
   end
endmodule
`default_nettype wire

// [rtl/conv_clock_gen.sv]
// Converter switching clock generator: divide by four or rate multiplier
`timescale 1ns/1ps
`default_nettype none
module conv_clock_gen (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic dig_tick,
   input wire logic rate_multiplier_enable,
   input wire logic [15:0] rate_multiplier_word,
   output logic sw_clk
);
   logic [1:0] div_reg, div_next;
   logic [15:0] acc_reg, acc_next;
   logic sw_reg, sw_next;
   logic [15:0] sum;

   // Accumulator wraps at 2^14: two toggles per period give word times rate over 2^15
   // Limitation: words from 2^14 to 2^15-1 saturate at one toggle per tick; bit 15 of the word is ignored
   always_comb begin
      div_next = div_reg;
      acc_next = acc_reg;
      sw_next = sw_reg;
      sum = {2'b00, acc_reg[13:0]} + {1'b0, rate_multiplier_word[14:0]};
      if (dig_tick) begin
         if (rate_multiplier_enable) begin
            acc_next = {2'b00, sum[13:0]};
            sw_next = sw_reg ^ (sum[15:14] != 2'b00);
         end else begin
            div_next = div_reg + 2'h1;
            sw_next = div_reg[1];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_reg <= 2'h0;
         acc_reg <= 16'h0000;
         sw_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         acc_reg <= acc_next;
         sw_reg <= sw_next;
      end
   end

   assign sw_clk = sw_reg;
endmodule
`default_nettype wire

// [rtl/power_reset_synth_config.sv]
// Power manager, reset and synthesizer configuration with AHB-Lite registers
// Operation
// - Level code 001 to 111 selects 1.2 V to 1.8 V in 0.1 V steps
// - Scope bit 1: programmed level in TX, fixed 1.4 V in RX
// - Scope bit 0: programmed level in both RX and TX
// - Multiplier off: switching clock is digital clock divided by four
// - Multiplier on: switching rate is word times digital clock over 2^15, for words below 2^14
// - Digital clock is crystal, or half crystal for double crystals
// - Low-power mode bypasses regulators; host programs 1.2 V
// - Internal reset held low for reset pulse width after supply
// - Shutdown release gives same pulse; reset shown on general pin zero
// - Power-on reset restores registers and state machine
// - Soft reset command resets only part of the block
// - Pad disable follows shutdown pin and disables digital pins
// - Calibrate on every lock request unless disabled, store word
// - Channel centre is base plus step times index, 256 channels
// - Base word is 28 bits, scaled by band and reference dividers
// - Band divider 4 when band bit 0, 8 when 1
// - Reference divider 1 when enable 0, 2 when 1
`timescale 1ns/1ps
`default_nettype none
module power_reset_synth_config #(
   parameter int RESET_CYC = prs_pkg::RESET_PULSE_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic shutdown_pin,
   output logic internal_reset_n,
   output logic general_io_zero,
   output logic pad_disable,
   output logic [2:0] conv_level_applied,
   output logic regulator_bypass,
   output logic conv_sw_clk,
   output logic [27:0] base_freq_word_out,
   output logic [3:0] band_ref_div,
   output logic [7:0] cal_word_out,
   output logic cal_busy
);
   // Registers
   logic [2:0] converter_level_sel_reg, converter_level_sel_next;
   logic converter_level_scope_reg, converter_level_scope_next;
   logic regulator_bypass_reg, regulator_bypass_next;
   logic rate_multiplier_enable_reg, rate_multiplier_enable_next;
   logic xo_double_reg, xo_double_next;
   logic [15:0] rate_multiplier_word_reg, rate_multiplier_word_next;
   logic [27:0] base_freq_word_reg, base_freq_word_next;
   logic band_select_reg, band_select_next;
   logic ref_divider_enable_reg, ref_divider_enable_next;
   logic cal_disable_reg, cal_disable_next;
   logic [7:0] channel_index_reg, channel_index_next;
   logic [7:0] channel_step_reg, channel_step_next;
   logic [2:0] pump_current_sel_reg, pump_current_sel_next;
   logic detector_split_enable_reg, detector_split_enable_next;
   logic [7:0] cal_tx_reg, cal_tx_next, cal_rx_reg, cal_rx_next;
   prs_pkg::radio_t state_reg, state_next;
   logic [2:0] lvl_out_reg, lvl_out_next;
   logic [3:0] cal_cnt_reg, cal_cnt_next;
   logic cal_tx_sel_reg, cal_tx_sel_next;
   logic [7:0] cal_out_reg, cal_out_next;
   logic cal_busy_reg;
   // Bus data-phase capture
   logic wr_pend_reg, wr_pend_next, rd_pend_reg, rd_pend_next;
   logic [7:0] addr_reg, addr_next;
   logic [31:0] rdata_reg, rdata_next;
   // Reset pulse generation
   logic [31:0] rst_cnt_reg, rst_cnt_next;
   logic rstn_reg, rstn_next, pad_reg, pad_next, sdn_q_reg;
   logic dig_tick_reg, dig_tick_next;
   logic sel, soft_rst, lock_req;
   logic [31:0] status_word;
   logic [7:0] cmd;

   assign sel = hsel && hready && htrans[1];
   assign cmd = hwdata[7:0];
   assign soft_rst = wr_pend_reg && addr_reg == prs_pkg::OFS_CMD && cmd == prs_pkg::CMD_SOFT_RESET;

   // Reset pulse: counts up after shutdown release; bus state restarts only on power-on reset
   always_comb begin
      rst_cnt_next = rst_cnt_reg;
      rstn_next = rstn_reg;
      pad_next = shutdown_pin;
      if (shutdown_pin) begin
         rst_cnt_next = 32'h0000_0000;
         rstn_next = 1'b0;
      end else if (sdn_q_reg) begin
         rst_cnt_next = 32'h0000_0000;
         rstn_next = 1'b0;
      end else if (!rstn_reg) begin
         if (rst_cnt_reg == 32'(RESET_CYC - 1)) begin
            rstn_next = 1'b1;
         end else begin
            rst_cnt_next = rst_cnt_reg + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_cnt_reg <= 32'h0000_0000;
         rstn_reg <= 1'b0;
         pad_reg <= 1'b1;
         sdn_q_reg <= 1'b0;
      end else begin
         rst_cnt_reg <= rst_cnt_next;
         rstn_reg <= rstn_next;
         pad_reg <= pad_next;
         sdn_q_reg <= shutdown_pin;
      end
   end

   // Lock requests: any move from ready to an active state or between TX and RX
   always_comb begin
      state_next = state_reg;
      lock_req = 1'b0;
      if (wr_pend_reg && addr_reg == prs_pkg::OFS_CMD) begin
         case (cmd)
            prs_pkg::CMD_TX: state_next = prs_pkg::RADIO_TX;
            prs_pkg::CMD_RX: state_next = prs_pkg::RADIO_RX;
            prs_pkg::CMD_LOCK: state_next = prs_pkg::RADIO_LOCK;
            prs_pkg::CMD_READY: state_next = prs_pkg::RADIO_READY;
            prs_pkg::CMD_SOFT_RESET: state_next = prs_pkg::RADIO_READY;
            default: state_next = state_reg;
         endcase
      end
      case (state_reg)
         prs_pkg::RADIO_READY: lock_req = state_next != prs_pkg::RADIO_READY;
         prs_pkg::RADIO_TX: lock_req = state_next == prs_pkg::RADIO_RX;
         prs_pkg::RADIO_RX: lock_req = state_next == prs_pkg::RADIO_TX;
         default: lock_req = 1'b0;
      endcase
   end

   // Calibration sequencer and level steering
   always_comb begin
      cal_cnt_next = cal_cnt_reg;
      cal_tx_sel_next = cal_tx_sel_reg;
      cal_out_next = cal_tx_sel_reg ? cal_tx_reg : cal_rx_reg;
      lvl_out_next = lvl_out_reg;
      if (lock_req && !cal_disable_reg) begin
         cal_cnt_next = 4'(prs_pkg::CAL_CYC);
         cal_tx_sel_next = state_next != prs_pkg::RADIO_RX;
      end else if (lock_req) begin
         cal_tx_sel_next = state_next != prs_pkg::RADIO_RX;
      end else if (cal_cnt_reg != 4'h0) begin
         cal_cnt_next = cal_cnt_reg - 4'h1;
      end
      if (state_reg == prs_pkg::RADIO_RX && converter_level_scope_reg) begin
         lvl_out_next = prs_pkg::LVL_RX_FIXED;
      end else if (converter_level_sel_reg >= prs_pkg::LVL_MIN) begin
         lvl_out_next = converter_level_sel_reg;
      end
   end

   // Bus address capture and read mux
   always_comb begin
      wr_pend_next = sel && hwrite;
      rd_pend_next = sel && !hwrite;
      addr_next = sel ? haddr[7:0] : addr_reg;
      dig_tick_next = xo_double_reg ? ~dig_tick_reg : 1'b1;
      status_word = {26'h000_0000, cal_busy, rstn_reg, pad_reg, lvl_out_reg};
      rdata_next = 32'h0000_0000;
      if (sel && !hwrite) begin
         case (haddr[7:0])
            prs_pkg::OFS_CONV: rdata_next = {25'h000_0000, xo_double_reg, rate_multiplier_enable_reg,
               regulator_bypass_reg, converter_level_scope_reg, converter_level_sel_reg};
            prs_pkg::OFS_RATE: rdata_next = {16'h0000, rate_multiplier_word_reg};
            prs_pkg::OFS_SYNTH: rdata_next = {1'b0, cal_disable_reg, ref_divider_enable_reg,
               band_select_reg, base_freq_word_reg};
            prs_pkg::OFS_CHAN: rdata_next = {16'h0000, channel_step_reg, channel_index_reg};
            prs_pkg::OFS_CTRL: rdata_next = {28'h000_0000, detector_split_enable_reg, pump_current_sel_reg};
            prs_pkg::OFS_STATUS: rdata_next = status_word;
            prs_pkg::OFS_CAL_TX: rdata_next = {24'h00_0000, cal_tx_reg};
            prs_pkg::OFS_CAL_RX: rdata_next = {24'h00_0000, cal_rx_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Register writes; calibration result writes back into the stored word
   always_comb begin
      converter_level_sel_next = converter_level_sel_reg;
      converter_level_scope_next = converter_level_scope_reg;
      regulator_bypass_next = regulator_bypass_reg;
      rate_multiplier_enable_next = rate_multiplier_enable_reg;
      xo_double_next = xo_double_reg;
      rate_multiplier_word_next = rate_multiplier_word_reg;
      base_freq_word_next = base_freq_word_reg;
      band_select_next = band_select_reg;
      ref_divider_enable_next = ref_divider_enable_reg;
      cal_disable_next = cal_disable_reg;
      channel_index_next = channel_index_reg;
      channel_step_next = channel_step_reg;
      pump_current_sel_next = pump_current_sel_reg;
      detector_split_enable_next = detector_split_enable_reg;
      cal_tx_next = cal_tx_reg;
      cal_rx_next = cal_rx_reg;
      if (wr_pend_reg) begin
         case (addr_reg)
            prs_pkg::OFS_CONV: begin
               converter_level_sel_next = hwdata[prs_pkg::CONV_LVL_LSB +: 3];
               converter_level_scope_next = hwdata[prs_pkg::CONV_SCOPE_BIT];
               regulator_bypass_next = hwdata[prs_pkg::CONV_BYPASS_BIT];
               rate_multiplier_enable_next = hwdata[prs_pkg::CONV_RATE_MULTIPLIER_ENABLE_BIT];
               xo_double_next = hwdata[prs_pkg::CONV_XO_DOUBLE_BIT];
            end
            prs_pkg::OFS_RATE: rate_multiplier_word_next = hwdata[15:0];
            prs_pkg::OFS_SYNTH: begin
               base_freq_word_next = hwdata[27:0];
               band_select_next = hwdata[prs_pkg::SYN_BAND_BIT];
               ref_divider_enable_next = hwdata[prs_pkg::SYN_REF_DIVIDER_ENABLE_BIT];
               cal_disable_next = hwdata[prs_pkg::SYN_CALDIS_BIT];
            end
            prs_pkg::OFS_CHAN: begin
               channel_index_next = hwdata[7:0];
               channel_step_next = hwdata[prs_pkg::CH_STEP_LSB +: 8];
            end
            prs_pkg::OFS_CTRL: begin
               pump_current_sel_next = hwdata[prs_pkg::CTRL_PUMP_LSB +: 3];
               detector_split_enable_next = hwdata[prs_pkg::CTRL_SPLIT_BIT];
            end
            prs_pkg::OFS_CAL_TX: cal_tx_next = hwdata[7:0];
            prs_pkg::OFS_CAL_RX: cal_rx_next = hwdata[7:0];
            default: cal_tx_next = cal_tx_reg;
         endcase
      end
      // Calibration ends by storing a word derived from channel step and base word (stand-in for VCO search)
      if (cal_cnt_reg == 4'h1) begin
         if (cal_tx_sel_reg) begin
            cal_tx_next = channel_step_reg ^ base_freq_word_reg[27:20];
         end else begin
            cal_rx_next = channel_step_reg ^ base_freq_word_reg[27:20];
         end
      end
   end

   // Full reset on power-on only; soft reset touches state machine, calibration counter and busy flag only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         converter_level_sel_reg <= prs_pkg::LVL_RESET;
         converter_level_scope_reg <= 1'b0;
         regulator_bypass_reg <= 1'b0;
         rate_multiplier_enable_reg <= 1'b0;
         xo_double_reg <= 1'b0;
         rate_multiplier_word_reg <= prs_pkg::KRM_RESET;
         base_freq_word_reg <= prs_pkg::BASE_FREQ_WORD_RESET;
         band_select_reg <= 1'b0;
         ref_divider_enable_reg <= 1'b0;
         cal_disable_reg <= 1'b0;
         channel_index_reg <= 8'h00;
         channel_step_reg <= 8'h00;
         pump_current_sel_reg <= 3'h0;
         detector_split_enable_reg <= 1'b0;
         cal_tx_reg <= prs_pkg::CAL_RESET;
         cal_rx_reg <= prs_pkg::CAL_RESET;
         state_reg <= prs_pkg::RADIO_READY;
         lvl_out_reg <= prs_pkg::LVL_RESET;
         cal_cnt_reg <= 4'h0;
         cal_tx_sel_reg <= 1'b1;
         cal_out_reg <= prs_pkg::CAL_RESET;
         cal_busy_reg <= 1'b0;
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
         rdata_reg <= 32'h0000_0000;
         dig_tick_reg <= 1'b0;
      end else begin
         converter_level_sel_reg <= converter_level_sel_next;
         converter_level_scope_reg <= converter_level_scope_next;
         regulator_bypass_reg <= regulator_bypass_next;
         rate_multiplier_enable_reg <= rate_multiplier_enable_next;
         xo_double_reg <= xo_double_next;
         rate_multiplier_word_reg <= rate_multiplier_word_next;
         base_freq_word_reg <= base_freq_word_next;
         band_select_reg <= band_select_next;
         ref_divider_enable_reg <= ref_divider_enable_next;
         cal_disable_reg <= cal_disable_next;
         channel_index_reg <= channel_index_next;
         channel_step_reg <= channel_step_next;
         pump_current_sel_reg <= pump_current_sel_next;
         detector_split_enable_reg <= detector_split_enable_next;
         cal_tx_reg <= cal_tx_next;
         cal_rx_reg <= cal_rx_next;
         state_reg <= soft_rst ? prs_pkg::RADIO_READY : state_next;
         lvl_out_reg <= lvl_out_next;
         cal_cnt_reg <= soft_rst ? 4'h0 : cal_cnt_next;
         cal_tx_sel_reg <= cal_tx_sel_next;
         cal_out_reg <= cal_out_next;
         cal_busy_reg <= !soft_rst && cal_cnt_next != 4'h0; // Same value the counter takes
         wr_pend_reg <= wr_pend_next;
         rd_pend_reg <= rd_pend_next;
         addr_reg <= addr_next;
         rdata_reg <= rdata_next;
         dig_tick_reg <= dig_tick_next;
      end
   end

   conv_clock_gen u_conv_clock_gen (
      .hclk(hclk),
      .hresetn(hresetn),
      .dig_tick(dig_tick_reg),
      .rate_multiplier_enable(rate_multiplier_enable_reg),
      .rate_multiplier_word(rate_multiplier_word_reg),
      .sw_clk(conv_sw_clk)
   );

   // Outputs straight from flip-flops; bus always ready, always OKAY
   assign hrdata = rdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign internal_reset_n = rstn_reg;
   assign general_io_zero = rstn_reg;
   assign pad_disable = pad_reg;
   assign conv_level_applied = lvl_out_reg;
   assign regulator_bypass = regulator_bypass_reg;
   assign base_freq_word_out = base_freq_word_reg;
   assign band_ref_div = {band_select_reg, ref_divider_enable_reg, 2'b00};
   assign cal_word_out = cal_out_reg;
   assign cal_busy = cal_busy_reg;

   // Checks
   property p_rx_fixed;
      @(posedge hclk) disable iff (!hresetn)
         (state_reg == prs_pkg::RADIO_RX && converter_level_scope_reg) |=> lvl_out_reg == prs_pkg::LVL_RX_FIXED;
   endproperty
   a_rx_fixed: assert property (p_rx_fixed) else $error("RX level not fixed");
   property p_no_zero_level;
      @(posedge hclk) disable iff (!hresetn) lvl_out_reg != 3'h0;
   endproperty
   a_no_zero_level: assert property (p_no_zero_level) else $error("Reserved level applied");
   property p_shared;
      @(posedge hclk) disable iff (!hresetn)
         (!converter_level_scope_reg && converter_level_sel_reg != 3'h0) ##1 $stable(converter_level_sel_reg)
            |-> lvl_out_reg == converter_level_sel_reg;
   endproperty
   a_shared: assert property (p_shared) else $error("Level not applied");
   property p_pad;
      @(posedge hclk) disable iff (!hresetn) shutdown_pin |=> pad_disable && !internal_reset_n;
   endproperty
   a_pad: assert property (p_pad) else $error("Pad not disabled");
   property p_gpio;
      @(posedge hclk) disable iff (!hresetn) general_io_zero == internal_reset_n;
   endproperty
   a_gpio: assert property (p_gpio) else $error("Reset not on pin zero");
   property p_cal;
      @(posedge hclk) disable iff (!hresetn) (lock_req && !cal_disable_reg && !soft_rst) |=> cal_busy [*8] ##1 !cal_busy;
   endproperty
   a_cal: assert property (p_cal) else $error("Calibration length wrong");
   property p_nocal;
      @(posedge hclk) disable iff (!hresetn) (lock_req && cal_disable_reg && !cal_busy) |=> !cal_busy;
   endproperty
   a_nocal: assert property (p_nocal) else $error("Calibration ran while disabled");
   property p_release;
      @(posedge hclk) disable iff (!hresetn) $rose(internal_reset_n) |-> rst_cnt_reg == 32'(RESET_CYC - 1);
   endproperty
   a_release: assert property (p_release) else $error("Reset pulse too short");
endmodule
`default_nettype wire

// [rtl/prs_pkg.sv]
// Constants for the power, reset and synthesizer configuration block
package prs_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CONV = 8'h00;
   localparam logic [7:0] OFS_RATE = 8'h04;
   localparam logic [7:0] OFS_SYNTH = 8'h08;
   localparam logic [7:0] OFS_CHAN = 8'h0C;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_CAL_TX = 8'h18;
   localparam logic [7:0] OFS_CAL_RX = 8'h1C;
   localparam logic [7:0] OFS_CMD = 8'h20;
   // Field positions in the converter register
   localparam int CONV_LVL_LSB = 0;
   localparam int CONV_SCOPE_BIT = 3;
   localparam int CONV_BYPASS_BIT = 4;
   localparam int CONV_RATE_MULTIPLIER_ENABLE_BIT = 5;
   localparam int CONV_XO_DOUBLE_BIT = 6;
   // Field positions in the synth register
   localparam int SYN_BAND_BIT = 28;
   localparam int SYN_REF_DIVIDER_ENABLE_BIT = 29;
   localparam int SYN_CALDIS_BIT = 30;
   // Field positions in the channel register
   localparam int CH_STEP_LSB = 8;
   // Field positions in the control register
   localparam int CTRL_PUMP_LSB = 0;
   localparam int CTRL_SPLIT_BIT = 3;
   // Command codes
   localparam logic [7:0] CMD_SOFT_RESET = 8'h70;
   localparam logic [7:0] CMD_LOCK = 8'h66;
   localparam logic [7:0] CMD_TX = 8'h60;
   localparam logic [7:0] CMD_RX = 8'h61;
   localparam logic [7:0] CMD_READY = 8'h62;
   // Reset values, fixed RX level and minimum level
   localparam logic [2:0] LVL_RESET = 3'h3;
   localparam logic [2:0] LVL_RX_FIXED = 3'h3;
   localparam logic [2:0] LVL_MIN = 3'h1;
   localparam logic [15:0] KRM_RESET = 16'h0000;
   localparam logic [27:0] BASE_FREQ_WORD_RESET = 28'h000_0000;
   localparam logic [7:0] CAL_RESET = 8'h00;
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int RESET_PULSE_US = 700;
   localparam int RESET_PULSE_CYC = RESET_PULSE_US * (CLK_HZ / 1_000_000);
   localparam int CAL_CYC = 8;
   localparam logic [1:0] CONV_DIV = 2'h3;
   // Radio states
   typedef enum logic [1:0] {
      RADIO_READY = 2'b00,
      RADIO_LOCK = 2'b01,
      RADIO_TX = 2'b10,
      RADIO_RX = 2'b11
   } radio_t;
endpackage
